/* core/ssmw_regs.sv */
// Contract
// - set flag on downstream system error
// - set flag on master abort as master
// - set flag on received target abort
// - set flag when signalling target abort
// - decode timing field reads fixed 01
// - parity flag needs master, enable, perr
// - back-to-back capable bit reads one
// - high-rate capable bit reads one
// - reserved status bits read zero
// - bottom field supplies address bits 31:20
// - top field supplies address bits 31:20
// - forward addresses inside inclusive window
// - window low nibbles read zero
// - window registers at 20h, 22h, reset zero
// - status register at 1eh, sixteen bits
`timescale 1ns/100ps
`default_nettype none
`include "ssmw_consts.svh"

module ssmw_regs
  import ssmw_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          rst_i,
  input  wire ssmw_cfg_req_t cfg_req_i,
  input  wire logic          cfg_valid_i,
  output logic [15:0]        cfg_rdata_o,
  input  wire ssmw_evt_t     evt_i,
  input  wire logic          parity_response_enable_i,
  input  wire logic [31:0]   mem_addr_i,
  input  wire logic          mem_valid_i,
  output logic               mem_forward_o,
  output ssmw_flags_t        flags_o
);

  // everything the block remembers, registered in one place
  typedef struct packed {
    ssmw_flags_t flags;   // sticky error flags
    logic [11:0] bottom;  // window bottom, address bits 31:20
    logic [11:0] top;     // window top, address bits 31:20
    logic [15:0] rdata;   // answer to the last read request
  } ssmw_state_t;

  ssmw_state_t st;
  ssmw_state_t next_st;
  ssmw_flags_t flag_events;
  ssmw_flags_t flag_clears;
  logic        hit;
  logic        window_empty;
  logic        rd_req;
  logic        wr_req;
  logic        wr_status;
  logic        wr_bottom;
  logic        wr_top;
  logic        clr_lane;
  logic        par_evt;

  // one-clear-bit helper: event wins over a simultaneous clear
  function automatic logic upd_flag(input logic cur, input logic evt,
                                    input logic clr);
    upd_flag = evt | (cur & ~clr);
  endfunction : upd_flag

  // a valid request that names this byte offset exactly
  function automatic logic at_offset(input ssmw_cfg_req_t req,
                                     input logic          valid,
                                     input logic [7:0]    ofs);
    at_offset = valid & (req.addr == ofs);
  endfunction : at_offset

  // byte-lane write of a window field; wdata bits 3:0 are dropped
  function automatic logic [11:0] merge_window(input logic [11:0] cur,
                                               input logic [15:0] wdata,
                                               input logic [1:0]  be);
    logic [11:0] f;
    f = cur;
    if (be[1]) begin
      f[11:4] = wdata[15:8];
    end
    if (be[0]) begin
      f[3:0] = wdata[7:4];
    end
    merge_window = f;
  endfunction : merge_window

  // read-back of a window field over its zero low nibble
  function automatic logic [15:0] window_word(input logic [11:0] f);
    window_word = {f, 4'h0};
  endfunction : window_word

  // write-one clear request per flag; all sit in the upper lane
  function automatic ssmw_flags_t clear_bits(input logic [15:0] wdata);
    ssmw_flags_t c;
    c.received_system_error_flag    = wdata[`SSMW_BIT_RECEIVED_SYSTEM_ERROR_FLAG];
    c.received_master_abort_flag    = wdata[`SSMW_BIT_RECEIVED_MASTER_ABORT_FLAG];
    c.received_target_abort_flag    = wdata[`SSMW_BIT_TABORT_RX];
    c.signalled_target_abort_flag   = wdata[`SSMW_BIT_TABORT_TX];
    c.master_data_parity_error_flag = wdata[`SSMW_BIT_DATA_PAR];
    clear_bits = c;
  endfunction : clear_bits

  // status word: sticky flags over the fixed capability pattern
  function automatic logic [15:0] status_word(input ssmw_flags_t f);
    logic [15:0] w;
    w = 16'h0000;
    w[`SSMW_BIT_RECEIVED_SYSTEM_ERROR_FLAG]   = f.received_system_error_flag;
    w[`SSMW_BIT_RECEIVED_MASTER_ABORT_FLAG]    = f.received_master_abort_flag;
    w[`SSMW_BIT_TABORT_RX] = f.received_target_abort_flag;
    w[`SSMW_BIT_TABORT_TX] = f.signalled_target_abort_flag;
    w[10:9] = `SSMW_DECODE_TIMING;
    w[`SSMW_BIT_DATA_PAR]  = f.master_data_parity_error_flag;
    w[7] = `SSMW_BACK_TO_BACK_CAPABLE_FLAG;
    w[5] = `SSMW_HIGH_RATE_CAP;
    status_word = w;
  endfunction : status_word

  // read-back mux; unmapped offsets read as zero
  function automatic logic [15:0] read_word(input logic [7:0]  addr,
                                            input ssmw_state_t s);
    logic [15:0] w;
    case (addr)
      `SSMW_OFS_STATUS:     w = status_word(s.flags);
      `SSMW_OFS_WIN_BOTTOM: w = window_word(s.bottom);
      `SSMW_OFS_WIN_TOP:    w = window_word(s.top);
      default:              w = 16'h0000;
    endcase
    read_word = w;
  endfunction : read_word

  // request decode; only exact byte offsets are answered
  assign rd_req    = cfg_valid_i & ~cfg_req_i.wr;
  assign wr_req    = cfg_valid_i & cfg_req_i.wr;
  assign wr_status = at_offset(cfg_req_i, wr_req,
                               `SSMW_OFS_STATUS);
  assign wr_bottom = at_offset(cfg_req_i, wr_req,
                               `SSMW_OFS_WIN_BOTTOM);
  assign wr_top    = at_offset(cfg_req_i, wr_req,
                               `SSMW_OFS_WIN_TOP);

  // all clearable flags live in the upper byte lane
  assign clr_lane    = wr_status & cfg_req_i.be[1];
  assign flag_clears = clr_lane ? clear_bits(cfg_req_i.wdata) : '0;

  // parity event needs mastership, the enable and a perr together
  assign par_evt = evt_i.is_master & parity_response_enable_i
                 & (evt_i.perr_driven_rd | evt_i.perr_seen_wr);

  // event pulses gathered in flag order, system error first
  assign flag_events = {evt_i.serr_seen,
                        evt_i.master_abort,
                        evt_i.target_abort_rx,
                        evt_i.target_abort_tx,
                        par_evt};

  // base above limit: no address can lie inside the window
  assign window_empty = (st.bottom > st.top);

  // inclusive compare against the programmed window
  ssmw_window_match u_match (
    .bottom_i (st.bottom),
    .top_i    (st.top),
    .addr_i   (mem_addr_i),
    .hit_o    (hit)
  );

  // next-state: flags, window fields, registered read data
  always_comb begin
    next_st = st;
    // each flag: a new event sets it, a write of one clears it
    next_st.flags.received_system_error_flag = upd_flag(
      st.flags.received_system_error_flag,
      flag_events.received_system_error_flag,
      flag_clears.received_system_error_flag);
    next_st.flags.received_master_abort_flag = upd_flag(
      st.flags.received_master_abort_flag,
      flag_events.received_master_abort_flag,
      flag_clears.received_master_abort_flag);
    next_st.flags.received_target_abort_flag = upd_flag(
      st.flags.received_target_abort_flag,
      flag_events.received_target_abort_flag,
      flag_clears.received_target_abort_flag);
    next_st.flags.signalled_target_abort_flag = upd_flag(
      st.flags.signalled_target_abort_flag,
      flag_events.signalled_target_abort_flag,
      flag_clears.signalled_target_abort_flag);
    next_st.flags.master_data_parity_error_flag = upd_flag(
      st.flags.master_data_parity_error_flag,
      flag_events.master_data_parity_error_flag,
      flag_clears.master_data_parity_error_flag);
    // window fields take whichever byte lanes are enabled
    if (wr_bottom) begin
      next_st.bottom = merge_window(st.bottom, cfg_req_i.wdata,
                                    cfg_req_i.be);
    end
    if (wr_top) begin
      next_st.top = merge_window(st.top, cfg_req_i.wdata,
                                 cfg_req_i.be);
    end
    // reads answer one cycle after the request, then fall to zero
    next_st.rdata = 16'h0000;
    if (rd_req) begin
      next_st.rdata = read_word(cfg_req_i.addr, st);
    end
  end

  // single state register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rdata_o   = st.rdata;
  assign mem_forward_o = mem_valid_i & hit & ~window_empty;
  assign flags_o       = st.flags;

endmodule : ssmw_regs
`default_nettype wire

/* core/ssmw_window_match.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ssmw_consts.svh"

// inclusive window compare on a 32-bit memory address
module ssmw_window_match
  import ssmw_pkg::*;
(
  input  wire logic [11:0] bottom_i,
  input  wire logic [11:0] top_i,
  input  wire logic [31:0] addr_i,
  output logic             hit_o
);

  logic [31:0] lo_addr;
  logic [31:0] hi_addr;

  // low 20 bits implied zero at the bottom, ones at the top
  assign lo_addr = {bottom_i, `SSMW_WIN_LOW_FILL};
  assign hi_addr = {top_i, `SSMW_WIN_HIGH_FILL};
  // base above limit leaves no address satisfying both compares
  assign hit_o = (addr_i >= lo_addr) && (addr_i <= hi_addr);

endmodule : ssmw_window_match
`default_nettype wire

/* inc/ssmw_consts.svh */
`ifndef SSMW_CONSTS_SVH
`define SSMW_CONSTS_SVH

// configuration byte offsets
`define SSMW_OFS_STATUS      8'h1e
`define SSMW_OFS_WIN_BOTTOM  8'h20
`define SSMW_OFS_WIN_TOP     8'h22

// status field positions
`define SSMW_BIT_RECEIVED_SYSTEM_ERROR_FLAG     14
`define SSMW_BIT_RECEIVED_MASTER_ABORT_FLAG      13
`define SSMW_BIT_TABORT_RX   12
`define SSMW_BIT_TABORT_TX   11
`define SSMW_BIT_DATA_PAR    8

// fixed read-back fields of the status register
`define SSMW_DECODE_TIMING   2'h1
`define SSMW_BACK_TO_BACK_CAPABLE_FLAG         1'h1
`define SSMW_HIGH_RATE_CAP   1'h1

// window fields
`define SSMW_WIN_MSB         15
`define SSMW_WIN_LSB         4
`define SSMW_WIN_RESET       16'h0000
`define SSMW_WIN_LOW_FILL    20'h00000
`define SSMW_WIN_HIGH_FILL   20'hfffff

`endif

/* inc/ssmw_pkg.sv */
package ssmw_pkg;

  // one configuration access, 16-bit word with byte enables
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [1:0]  be;
  } ssmw_cfg_req_t;

  // event pulses observed on the downstream bus
  typedef struct packed {
    logic serr_seen;
    logic master_abort;
    logic target_abort_rx;
    logic target_abort_tx;
    logic is_master;
    logic perr_driven_rd;
    logic perr_seen_wr;
  } ssmw_evt_t;

  typedef struct packed {
    logic received_system_error_flag;
    logic received_master_abort_flag;
    logic received_target_abort_flag;
    logic signalled_target_abort_flag;
    logic master_data_parity_error_flag;
  } ssmw_flags_t;

endpackage : ssmw_pkg

/* test/ssmw_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module ssmw_assertions
  import ssmw_pkg::*;
(
  input wire logic          ref_clk_i,
  input wire logic          rst_i,
  input wire ssmw_cfg_req_t cfg_req_i,
  input wire logic          cfg_valid_i,
  input wire logic [15:0]   cfg_rdata_o,
  input wire ssmw_evt_t     evt_i,
  input wire logic          parity_response_enable_i,
  input wire logic          mem_valid_i,
  input wire logic          mem_forward_o,
  input wire ssmw_flags_t   flags_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // parity event needs mastership, enable and a perr together
  wire par_ev = evt_i.is_master & parity_response_enable_i &
                (evt_i.perr_driven_rd | evt_i.perr_seen_wr);
  // status read, and a write-one clear of the system error flag
  sequence st_rd;
    cfg_valid_i && !cfg_req_i.wr && cfg_req_i.addr == 8'h1e;
  endsequence
  sequence clr_sys;
    cfg_valid_i && cfg_req_i.wr && cfg_req_i.addr == 8'h1e &&
    cfg_req_i.be[1] && cfg_req_i.wdata[14] && !evt_i.serr_seen;
  endsequence
  serr_set_a: assert property (evt_i.serr_seen |=>
    flags_o.received_system_error_flag) else $error("serr flag");
  received_master_abort_flag_set_a: assert property (evt_i.master_abort |=>
    flags_o.received_master_abort_flag) else $error("received_master_abort_flag flag");
  tabort_rx_a: assert property (evt_i.target_abort_rx |=>
    flags_o.received_target_abort_flag) else $error("tabort rx flag");
  tabort_tx_a: assert property (evt_i.target_abort_tx |=>
    flags_o.signalled_target_abort_flag) else $error("tabort tx flag");
  par_set_a: assert property (par_ev |=>
    flags_o.master_data_parity_error_flag) else $error("parity flag");
  par_hold_a: assert property (!par_ev &&
    !flags_o.master_data_parity_error_flag |=>
    !flags_o.master_data_parity_error_flag) else $error("parity stray");
  status_fixed_a: assert property (st_rd |=>
    cfg_rdata_o[10:9] == 2'h1 && cfg_rdata_o[7:0] == 8'ha0)
    else $error("status fixed bits");
  sys_clear_a: assert property (clr_sys |=>
    !flags_o.received_system_error_flag) else $error("clear failed");
  no_forward_a: assert property (!mem_valid_i |->
    !mem_forward_o) else $error("forward without valid");
endmodule : ssmw_assertions
bind ssmw_regs ssmw_assertions i_ssmw_assertions (.ref_clk_i, .rst_i,
  .cfg_req_i, .cfg_valid_i, .cfg_rdata_o, .evt_i,
  .parity_response_enable_i, .mem_valid_i, .mem_forward_o, .flags_o);
`default_nettype wire

/* test/ssmw_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module ssmw_regs_tb
  import ssmw_pkg::*;
;
  logic ref_clk_i = 0, rst_i = 1, vld = 0, pen = 0, mv = 0, fwd;
  ssmw_cfg_req_t req = '0;
  ssmw_evt_t evt = '0;
  ssmw_flags_t flags;
  logic [15:0] rdata, rd, b, t;
  logic [31:0] addr = '0, pts [5];
  logic [6:0] e;
  int n_errors = 0, cmp_count = 0, seed = 55;
  ssmw_regs i_ssmw_regs (.ref_clk_i, .rst_i, .cfg_req_i(req),
    .cfg_valid_i(vld), .cfg_rdata_o(rdata), .evt_i(evt),
    .parity_response_enable_i(pen), .mem_addr_i(addr), .mem_valid_i(mv),
    .mem_forward_o(fwd), .flags_o(flags));
  // free-running 250 MHz clock
  always #2 ref_clk_i = ~ref_clk_i;
  task chk(input logic [15:0] s, x);
    cmp_count++;
    if (s !== x) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  // one access with an event pulse riding on the same edge
  task cfg(input logic w, input logic [7:0] ad, input logic [15:0] d,
           input logic [1:0] be, input logic [6:0] ev);
    @(negedge ref_clk_i);
    req <= '{w, ad, d, be};
    vld <= 1;
    evt <= ev;
    @(negedge ref_clk_i);
    rd = rdata;
    vld <= 0;
    evt <= '0;
  endtask : cfg
  function logic [15:0] sts(input logic [6:0] v, input logic en);
    return {1'b0, v[6:3], 2'h1, v[2] & en & (v[1] | v[0]), 8'ha0};
  endfunction : sts
  function logic [15:0] fl(input logic [6:0] v, input logic en);
    return {11'h000, v[6:3], v[2] & en & (v[1] | v[0])};
  endfunction : fl
  function logic fw(input logic [31:0] x, input logic [15:0] lo, hi);
    return x >= {lo[15:4], 20'h0} && x <= {hi[15:4], 20'hfffff};
  endfunction : fw
  task results;
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // watchdog, far beyond the roughly 700 cycles of the run
  initial begin
    #100000;
    n_errors++;
    results();
  end
  // main sequence
  initial begin
    repeat (10) @(negedge ref_clk_i);
    rst_i <= 0;
    cfg(1, 8'h1e, 16'hffff, 2'h3, 0);
    for (int i = 0; i < 4; i++) begin
      cfg(0, 8'(30 + 2 * i), 0, 0, 0);
      chk(rd, i == 0 ? 16'h02a0 : 16'h0);
      @(negedge ref_clk_i);
      chk(rdata, 16'h0000);
    end
    // random events, read back, then write-one clear of everything
    repeat (40) begin
      e = 7'($random(seed));
      pen <= 1'($random(seed));
      cfg(0, 8'h30, 0, 0, e);
      chk(rd, 16'h0000);
      chk({11'h000, flags}, fl(e, pen));
      cfg(0, 8'h1e, 0, 0, 0);
      chk(rd, sts(e, pen));
      cfg(1, 8'h1e, 16'hffff, 2'h3, 0);
      chk({11'h000, flags}, 16'h0000);
    end
    // low byte cannot clear; an event beats a clear
    cfg(0, 8'h30, 0, 0, 7'h40);
    cfg(1, 8'h1e, 16'hffff, 2'h1, 0);
    cfg(1, 8'h1e, 16'h4000, 2'h2, 7'h40);
    cfg(0, 8'h1e, 0, 0, 0);
    chk(rd, 16'h42a0);
    cfg(1, 8'h1e, 16'h4000, 2'h2, 0);
    cfg(0, 8'h1e, 0, 0, 0);
    chk(rd, 16'h02a0);
    // random windows, probed at both edges and just outside
    repeat (30) begin
      b = 16'($random(seed));
      t = 16'($random(seed));
      cfg(1, 8'h20, b, 2'h3, 0);
      cfg(1, 8'h22, t, 2'h3, 0);
      cfg(0, 8'h20, 0, 0, 0);
      chk(rd, b & 16'hfff0);
      cfg(0, 8'h22, 0, 0, 0);
      chk(rd, t & 16'hfff0);
      pts = '{{b[15:4], 20'h0}, {t[15:4], 20'hfffff},
              {b[15:4], 20'h0} - 1, {t[15:4], 20'hfffff} + 1, $random(seed)};
      for (int j = 0; j < 5; j++) begin
        @(negedge ref_clk_i);
        addr <= pts[j];
        mv <= 1'($random(seed)) | (j < 4);
        #1;
        chk({15'h0, fwd}, {15'h0, mv & fw(pts[j], b, t)});
      end
    end
    // mid-run reset with flags and windows loaded, then zeros again
    cfg(0, 8'h30, 16'h0000, 2'h0, 7'h78);
    @(negedge ref_clk_i);
    rst_i <= 1;
    repeat (3) @(negedge ref_clk_i);
    rst_i <= 0;
    chk({11'h000, flags}, 16'h0000);
    cfg(0, 8'h20, 16'h0000, 2'h0, 7'h00);
    chk(rd, 16'h0000);
    cfg(0, 8'h22, 16'h0000, 2'h0, 7'h00);
    chk(rd, 16'h0000);
    cfg(0, 8'h1e, 16'h0000, 2'h0, 7'h00);
    chk(rd, 16'h02a0);
    results();
  end
endmodule : ssmw_regs_tb
`default_nettype wire
